// [verilog/mvsp_pkg.sv]
// package: constants, types and stepping helpers for the motion-vector surface port
package mvsp_pkg;
    // ========== register map (byte addresses)
    localparam logic [11:0] OFF_PARM = 12'h000;
    localparam logic [11:0] OFF_LEFT = 12'h004;
    localparam logic [11:0] OFF_POS = 12'h008;
    localparam logic [11:0] OFF_STAT = 12'h00c;
    localparam logic [11:0] OFF_CMD = 12'h010;
    localparam logic [2:0] STAGE_SEL = 3'h1;
    localparam logic [1:0] RESULT_SEL = 2'h1;
    // ========== fields
    localparam int STAT_RD_DONE = 5;
    localparam int STAT_OUT_FULL = 6;
    localparam int STAT_GATHER = 7;
    localparam int CMD_SUB_LSB = 5;
    localparam logic [4:0] OP_WRITE = 5'h0a;
    localparam logic [4:0] OP_READ = 5'h09;
    localparam logic [2:0] SUBOP_MV = 3'h1;
    localparam int MV_Y_LSB = 14;
    localparam int AUX_LSB = 26;
    // ========== sizes and timing counts
    localparam logic [3:0] MB_LAST = 4'hf;
    localparam logic [4:0] PAIR_LAST = 5'h1f;
    localparam logic [1:0] PF_DEPTH = 2'h2;
    localparam logic [4:0] GATHER_END = 5'h10;
    localparam logic [4:0] SUBMIT_CYC = 5'h11;
    localparam logic [5:0] RD_MIN_CYC = 6'h25;
    // ========== reset values
    localparam logic [8:0] PARM_RST = 9'h000;
    localparam logic [28:0] RDPOS_RST = 29'h0;

    typedef struct packed {
        logic prog;
        logic [7:0] width;
    } mvsp_parm_t;

    typedef struct packed {
        logic pass;
        logic [11:0] pos;
        logic [7:0] lines;
        logic [7:0] left;
    } mvsp_rdpos_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_COPY = 2'b11,
        RD_HOLD = 2'b10
    } mvsp_rdst_t;

    // advance the read position by one pair, wrapping lines and passes
    function automatic mvsp_rdpos_t mvsp_step(mvsp_rdpos_t s, mvsp_parm_t p);
        mvsp_rdpos_t n;
        n = s;
        n.left = s.left - 8'h01;
        n.pos = s.pos + 12'h001;
        if (n.left == 8'h00) begin
            n.left = p.width;
            if (p.prog && !s.pass) begin
                n.pass = 1'b1;
                n.pos = n.pos - {4'h0, p.width};
            end else begin
                n.pass = 1'b0;
                n.lines = s.lines - 8'h01;
            end
        end
        return n;
    endfunction
endpackage

// [verilog/mvsp_top.sv]
// motion-vector surface port: prefetching pair reader and gathering macroblock writer
//
// Behaviour
// - a pair read fetches at position, count-in-line minus one, position plus one
// - count-in-line reaching zero reloads from the line width
// - progressive line end on first pass: set pass, step position back a width
// - interlaced or second pass line end: clear pass, lines left minus one
// - with either count zero a read fails and changes no read register
// - two-pair prefetch buffer, filling whenever both counts are nonzero
// - write-only staging space of 128 cells, 16 bits, sparsely implemented
// - staging layout: x, y, zero flag per subpartition; id per partition; flags, scheme shared
// - ignored address fields alias onto one stored datum
// - read-only result space of 256 cells, per macroblock base, sign-extended vectors
// - write gathers per partitioning scheme, duplicating coarse partitions
// - writes while the output buffer is full are ignored
// - gather bit set end of cycle 1, cleared end of cycle 17
// - a write that fills the buffer sets full together with gather
// - packed word layout: x low, y from 14, aux bits from 26
// - write instruction submits to the output queue in 18 cycles
// - read instruction fetches a pair, at least 37 cycles, unbounded
// - read-done cleared in cycle 1, set once the pair is stored
// - failed read never sets read-done; read-done is zero after reset
// - parameter register: width bits 0-7, progressive bit 8
// - remaining register: pairs left bits 0-7, lines left bits 8-15
// - position register: pair index bits 0-11, pass flag bit 12
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
module mvsp_top
    import mvsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_rd_req,
    output logic [11:0] mem_rd_pair_addr,
    input wire logic mem_rd_ack,
    input wire logic mem_rd_valid,
    input wire logic [31:0] mem_rd_data,
    output logic mem_wr_valid,
    output logic [31:0] mem_wr_data,
    output logic mem_wr_last,
    input wire logic mem_wr_ready
);
    import mvsp_pkg::*;

    // ==================== declarations
    mvsp_parm_t parm_reg;
    mvsp_rdpos_t rdpos_reg;
    mvsp_rdpos_t fpos_reg;
    mvsp_rdst_t rd_state_reg;
    logic load_pend_reg;
    logic in_flight_reg;
    logic [4:0] fidx_reg;
    logic [31:0] pf_mem [0:63];
    logic pf_head_reg;
    logic pf_tail_reg;
    logic [1:0] pf_cnt_reg;
    logic [31:0] res_words [0:31];
    logic [4:0] cidx_reg;
    logic [5:0] rcnt_reg;
    logic rd_done_reg;
    logic [13:0] stg_x [0:15];
    logic [11:0] stg_y [0:15];
    logic [15:0] stg_zero_reg;
    logic [4:0] stg_rpi [0:3];
    logic [1:0] stg_flags_reg;
    logic [9:0] stg_part_reg;
    logic [31:0] out_words [0:15];
    logic [4:0] gcnt_reg;
    logic gather_reg;
    logic out_full_reg;
    logic [3:0] oidx_reg;
    logic apb_acc;
    logic apb_wr;
    logic cmd_write;
    logic cmd_read;
    logic rd_finish;
    logic push;
    logic counts_ok;
    logic [6:0] scell;

    // ==================== helpers
    // partition lookup swaps the two mode bits, giving a mask of the index bits kept distinct (cleared bits are shared)
    function automatic logic [3:0] sub_mask(logic [9:0] part, logic [1:0] pidx);
        logic [1:0] sp;
        sp = part[2*pidx+2 +: 2];
        return {part[0], part[1], sp[0], sp[1]};
    endfunction

    // build packed word w of the macroblock from staging cells
    function automatic logic [31:0] gather_word(logic [3:0] w);
        logic [3:0] m;
        logic [3:0] msp;
        logic [31:0] r;
        m = sub_mask(stg_part_reg, w[3:2]);
        msp = w & m;
        r = '0;
        r[13:0] = stg_x[msp];
        r[MV_Y_LSB +: 12] = stg_y[msp];
        if (w[1:0] == 2'h0) begin
            r[AUX_LSB +: 5] = stg_rpi[w[3:2] & m[3:2]];
        end else if (w[1:0] == 2'h1) begin
            for (int k = 0; k < 4; k++) begin
                r[AUX_LSB+k] = stg_zero_reg[{w[3:2], 2'(k)} & m];
            end
        end else if (w == MB_LAST) begin
            r[AUX_LSB +: 2] = stg_flags_reg;
        end
        return r;
    endfunction

    // decode one result cell; ignored fields simply drop out of the index
    function automatic logic [15:0] result_cell(logic [7:0] a);
        logic [4:0] b;
        logic [31:0] wd;
        logic [15:0] r;
        b = {a[7], a[6:3]};
        r = '0;
        unique case (a[2:0])
            3'h0: begin
                wd = res_words[b];
                r = {{2{wd[13]}}, wd[13:0]};
            end
            3'h1: begin
                wd = res_words[b];
                r = {{4{wd[25]}}, wd[25:14]};
            end
            3'h2: begin
                wd = res_words[{a[7], a[6:5], 2'h0}];
                r = {11'h0, wd[30:26]};
            end
            3'h3: begin
                wd = res_words[{a[7], a[6:5], 2'h1}];
                r = {15'h0, wd[AUX_LSB + a[4:3]]};
            end
            default: begin
                wd = res_words[{a[7], MB_LAST}];
                r = {14'h0, wd[27:26]};
            end
        endcase
        return r;
    endfunction

    // ==================== apb slave
    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite;
    assign cmd_write = apb_wr && paddr == OFF_CMD && pwdata[4:0] == OP_WRITE
        && pwdata[CMD_SUB_LSB +: 3] == SUBOP_MV;
    assign cmd_read = apb_wr && paddr == OFF_CMD && pwdata[4:0] == OP_READ
        && pwdata[CMD_SUB_LSB +: 3] == SUBOP_MV;
    assign scell = paddr[8:2];

    // one wait state; read data and error are captured with pready
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && penable && !pready) begin
                if (paddr[11:9] == STAGE_SEL) begin
                    prdata <= '0;
                end else if (paddr[11:10] == RESULT_SEL) begin
                    prdata <= {16'h0, result_cell(paddr[9:2])};
                end else begin
                    unique case (paddr)
                        OFF_PARM: prdata <= {23'h0, parm_reg};
                        OFF_LEFT: prdata <= {16'h0, rdpos_reg.lines, rdpos_reg.left};
                        OFF_POS: prdata <= {19'h0, rdpos_reg.pass, rdpos_reg.pos};
                        OFF_STAT: prdata <= {24'h0, gather_reg, out_full_reg, rd_done_reg, 5'h0};
                        OFF_CMD: prdata <= '0;
                        default: pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end

    // ==================== read-side registers
    assign counts_ok = rdpos_reg.left != 8'h00 && rdpos_reg.lines != 8'h00;
    assign rd_finish = rd_state_reg == RD_HOLD && rcnt_reg >= RD_MIN_CYC - 6'h01;

    // software writes win; hardware steps only when a read completes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            parm_reg <= PARM_RST;
            rdpos_reg <= RDPOS_RST;
        end else if (apb_wr && paddr == OFF_PARM) begin
            parm_reg <= pwdata[8:0];
        end else if (apb_wr && paddr == OFF_LEFT) begin
            rdpos_reg.lines <= pwdata[15:8];
            rdpos_reg.left <= pwdata[7:0];
        end else if (apb_wr && paddr == OFF_POS) begin
            rdpos_reg.pass <= pwdata[12];
            rdpos_reg.pos <= pwdata[11:0];
        end else if (rd_finish) begin
            rdpos_reg <= mvsp_step(rdpos_reg, parm_reg);
        end
    end

    // ==================== prefetch
    // fetch position runs ahead of the visible one; any setup write resyncs it
    assign push = mem_rd_valid && in_flight_reg && fidx_reg == PAIR_LAST;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            load_pend_reg <= 1'b0;
            fpos_reg <= RDPOS_RST;
            mem_rd_req <= 1'b0;
            mem_rd_pair_addr <= '0;
            in_flight_reg <= 1'b0;
        end else begin
            load_pend_reg <= apb_wr && (paddr == OFF_PARM || paddr == OFF_LEFT || paddr == OFF_POS);
            if (load_pend_reg) begin
                fpos_reg <= rdpos_reg;
            end else if (mem_rd_req && mem_rd_ack) begin
                fpos_reg <= mvsp_step(fpos_reg, parm_reg);
            end
            if (mem_rd_req && mem_rd_ack) begin
                mem_rd_req <= 1'b0;
                in_flight_reg <= 1'b1;
            end else if (!mem_rd_req && !in_flight_reg && !load_pend_reg && pf_cnt_reg < PF_DEPTH
                    && fpos_reg.left != 8'h00 && fpos_reg.lines != 8'h00) begin
                mem_rd_req <= 1'b1;
                mem_rd_pair_addr <= fpos_reg.pos;
            end
            if (push) begin
                in_flight_reg <= 1'b0;
            end
        end
    end

    // pair words arrive one per valid, top macroblock first
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fidx_reg <= '0;
            pf_tail_reg <= 1'b0;
            pf_head_reg <= 1'b0;
            pf_cnt_reg <= '0;
        end else begin
            if (mem_rd_valid && in_flight_reg) begin
                pf_mem[{pf_tail_reg, fidx_reg}] <= mem_rd_data;
                fidx_reg <= fidx_reg + 5'h01;
            end
            if (load_pend_reg) begin
                pf_cnt_reg <= '0;
                pf_head_reg <= pf_tail_reg ^ push;
            end else begin
                pf_cnt_reg <= pf_cnt_reg + {1'b0, push} - {1'b0, rd_finish};
                if (rd_finish) begin
                    pf_head_reg <= ~pf_head_reg;
                end
            end
            if (push) begin
                pf_tail_reg <= ~pf_tail_reg;
            end
        end
    end

    // ==================== read instruction
    // a short wait is padded so completion never comes sooner than the minimum
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_state_reg <= RD_IDLE;
            rcnt_reg <= '0;
            cidx_reg <= '0;
            rd_done_reg <= 1'b0;
        end else begin
            if (rd_state_reg != RD_IDLE && rcnt_reg != 6'h3f) begin
                rcnt_reg <= rcnt_reg + 6'h01;
            end
            unique case (rd_state_reg)
                RD_IDLE: begin
                    if (cmd_read) begin
                        rd_done_reg <= 1'b0;
                        rcnt_reg <= 6'h01;
                        if (counts_ok) begin
                            rd_state_reg <= RD_WAIT;
                        end
                    end
                end
                RD_WAIT: begin
                    cidx_reg <= '0;
                    if (pf_cnt_reg != 2'h0 && !load_pend_reg) begin
                        rd_state_reg <= RD_COPY;
                    end
                end
                RD_COPY: begin
                    res_words[cidx_reg] <= pf_mem[{pf_head_reg, cidx_reg}];
                    cidx_reg <= cidx_reg + 5'h01;
                    if (cidx_reg == PAIR_LAST) begin
                        rd_state_reg <= RD_HOLD;
                    end
                end
                RD_HOLD: begin
                    if (rd_finish) begin
                        rd_done_reg <= 1'b1;
                        rd_state_reg <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ==================== staging cells
    // only implemented cells store; the rest of the space is dropped
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                stg_x[i] <= '0;
                stg_y[i] <= '0;
            end
            for (int i = 0; i < 4; i++) begin
                stg_rpi[i] <= '0;
            end
            stg_zero_reg <= '0;
            stg_flags_reg <= '0;
            stg_part_reg <= '0;
        end else if (apb_wr && paddr[11:9] == STAGE_SEL) begin
            unique case (scell[2:0])
                3'h0: stg_x[scell[6:3]] <= pwdata[13:0];
                3'h1: stg_y[scell[6:3]] <= pwdata[11:0];
                3'h2: stg_rpi[scell[6:5]] <= pwdata[4:0];
                3'h3: stg_zero_reg[scell[6:3]] <= pwdata[0];
                3'h4: begin
                    if (scell[4:3] == 2'h0) begin
                        stg_flags_reg <= pwdata[1:0];
                    end
                end
                3'h5: begin
                    if (scell[4:3] == 2'h0) begin
                        stg_part_reg <= pwdata[9:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==================== write instruction and output queue
    // single-macroblock queue, so every accepted write fills it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gcnt_reg <= '0;
            gather_reg <= 1'b0;
            out_full_reg <= 1'b0;
            oidx_reg <= '0;
            mem_wr_valid <= 1'b0;
            mem_wr_data <= '0;
            mem_wr_last <= 1'b0;
        end else begin
            if (gcnt_reg == 5'h00) begin
                if (cmd_write && !out_full_reg) begin
                    gcnt_reg <= 5'h01;
                    gather_reg <= 1'b1;
                    out_full_reg <= 1'b1;
                end
            end else if (gcnt_reg <= GATHER_END) begin
                out_words[4'(gcnt_reg - 5'h01)] <= gather_word(4'(gcnt_reg - 5'h01));
                gcnt_reg <= gcnt_reg + 5'h01;
                if (gcnt_reg == GATHER_END) begin
                    gather_reg <= 1'b0;
                end
            end else if (gcnt_reg == SUBMIT_CYC) begin
                gcnt_reg <= '0;
                mem_wr_valid <= 1'b1;
                mem_wr_data <= out_words[0];
                mem_wr_last <= 1'b0;
                oidx_reg <= '0;
            end
            if (mem_wr_valid && mem_wr_ready) begin
                if (oidx_reg == MB_LAST) begin
                    mem_wr_valid <= 1'b0;
                    mem_wr_last <= 1'b0;
                    out_full_reg <= 1'b0;
                end else begin
                    oidx_reg <= oidx_reg + 4'h1;
                    mem_wr_data <= out_words[oidx_reg + 4'h1];
                    mem_wr_last <= oidx_reg + 4'h1 == MB_LAST;
                end
            end
        end
    end

    // ==================== checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_gather_on;
        gather_reg [*8];
    endsequence

    chk_read_fail_quiet: assert property ((cmd_read && rd_state_reg == RD_IDLE && !counts_ok)
        |=> $stable(rdpos_reg) && rd_state_reg == RD_IDLE && !rd_done_reg)
        else $error("failed read changed read state");
    chk_pos_advance: assert property ((rd_finish && rdpos_reg.left != 8'h01)
        |=> rdpos_reg.pos == $past(rdpos_reg.pos) + 12'h001 && rdpos_reg.left == $past(rdpos_reg.left) - 8'h01)
        else $error("pair position did not advance");
    chk_line_reload: assert property ((rd_finish && rdpos_reg.left == 8'h01 && !apb_wr)
        |=> rdpos_reg.left == $past(parm_reg.width))
        else $error("line count not reloaded");
    chk_second_pass: assert property ((rd_finish && rdpos_reg.left == 8'h01 && parm_reg.prog && !rdpos_reg.pass
        && !apb_wr) |=> rdpos_reg.pass && rdpos_reg.lines == $past(rdpos_reg.lines))
        else $error("second pass not started");
    chk_line_done: assert property ((rd_finish && rdpos_reg.left == 8'h01 && (!parm_reg.prog || rdpos_reg.pass)
        && !apb_wr) |=> !rdpos_reg.pass && rdpos_reg.lines == $past(rdpos_reg.lines) - 8'h01)
        else $error("line not retired");
    chk_gather_window: assert property ((cmd_write && gcnt_reg == 5'h00 && !out_full_reg)
        |=> s_gather_on ##1 s_gather_on ##1 !gather_reg)
        else $error("gather bit window wrong");
    chk_full_with_gather: assert property ((cmd_write && gcnt_reg == 5'h00 && !out_full_reg)
        |=> out_full_reg && gather_reg)
        else $error("full not set with gather");
    chk_write_ignored: assert property ((cmd_write && out_full_reg && gcnt_reg == 5'h00)
        |=> gcnt_reg == 5'h00 && !gather_reg)
        else $error("write accepted while full");
    chk_done_cleared: assert property ((cmd_read && rd_state_reg == RD_IDLE) |=> !rd_done_reg)
        else $error("read-done not cleared");
    chk_read_min: assert property ($rose(rd_done_reg) |-> $past(rcnt_reg) >= RD_MIN_CYC - 6'h01)
        else $error("read finished too early");
    chk_prefetch_go: assert property ((!mem_rd_req && !in_flight_reg && !load_pend_reg && pf_cnt_reg == 2'h0
        && fpos_reg.left != 8'h00 && fpos_reg.lines != 8'h00) |=> mem_rd_req)
        else $error("prefetch did not start");
endmodule

// [dv/mvsp_mem_model.sv]
// memory-side partner: answers pair fetches with gapped words and stalls the write drain
`timescale 1ns/1ns
module mvsp_mem_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic mem_rd_req,
    input wire logic [11:0] mem_rd_pair_addr,
    output logic mem_rd_ack,
    output logic mem_rd_valid,
    output logic [31:0] mem_rd_data,
    output logic mem_wr_ready
);
    logic [31:0] r_reg;
    logic [11:0] a_reg;
    logic [5:0] cnt_reg;
    // ==========
    // one fetch at a time; random ack delay, gaps and stalls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {r_reg, a_reg, cnt_reg} <= {32'h00c0ffee, 12'h000, 6'h00};
            {mem_rd_ack, mem_rd_valid, mem_rd_data, mem_wr_ready} <= 35'h0;
        end else begin
            r_reg <= {r_reg[30:0], r_reg[31] ^ r_reg[21] ^ r_reg[1] ^ r_reg[0]};
            mem_rd_ack <= 1'b0;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data; // no stale word lingers between beats
            mem_wr_ready <= r_reg[3] | r_reg[5];
            if (cnt_reg != 6'h00) begin
                if (r_reg[0]) begin
                    mem_rd_valid <= 1'b1;
                    mem_rd_data <= {a_reg[5:0], 6'h20 - cnt_reg, a_reg[7:0] ^ 8'h5a, 6'h20 - cnt_reg, a_reg[5:0]};
                    cnt_reg <= cnt_reg - 6'h01;
                end
            end else if (mem_rd_req && r_reg[2]) begin
                mem_rd_ack <= 1'b1;
                a_reg <= mem_rd_pair_addr;
                cnt_reg <= 6'h20;
            end
        end
    end
endmodule

// [dv/testbench.sv]
// self-checking bench for the motion-vector surface port
`timescale 1ns/1ns
module testbench;
    import mvsp_pkg::*;
    logic core_clk = 1'b0;
    logic rstn;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [11:0] paddr = 12'h000, mem_rd_pair_addr, pos;
    logic [31:0] pwdata = 32'h0, prdata, mem_rd_data, mem_wr_data, q, w, rnd = 32'h0001168b;
    logic pready, pslverr, mem_rd_req, mem_rd_ack, mem_rd_valid, mem_wr_valid, mem_wr_last, mem_wr_ready, pass;
    logic [7:0] left, lines;
    logic [13:0] sx[16];
    logic [11:0] sy[16];
    logic zf[16];
    logic [4:0] reference_picture_id[4];
    logic [1:0] flg;
    logic [32:0] outq[$];
    int n_mismatch = 0, samples_checked = 0;
    always #5 core_clk = ~core_clk;
    mvsp_top uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_rd_req(mem_rd_req), .mem_rd_pair_addr(mem_rd_pair_addr), .mem_rd_ack(mem_rd_ack),
        .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
        .mem_wr_data(mem_wr_data), .mem_wr_last(mem_wr_last), .mem_wr_ready(mem_wr_ready));
    mvsp_mem_model partner (.core_clk(core_clk), .rstn(rstn), .mem_rd_req(mem_rd_req),
        .mem_rd_pair_addr(mem_rd_pair_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data), .mem_wr_ready(mem_wr_ready));
    // collect every output word taken by the drain
    always @(posedge core_clk) if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) outq.push_back({mem_wr_last, mem_wr_data});
    // ==========
    // helpers
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] mw(input logic [11:0] a, input logic [5:0] k);
        return {a[5:0], k, a[7:0] ^ 8'h5a, k, a[5:0]};
    endfunction
    function automatic logic [31:0] expw(input int i);
        logic [31:0] v;
        v = {6'h00, sy[i & 8], sx[i & 8]}; // coarse 16x8: only subpartitions 0 and 8 feed
        if ((i & 3) == 1) v[29:26] = {4{zf[i & 8]}};
        if ((i & 3) == 0) v[30:26] = reference_picture_id[(i >> 2) & 2];
        if (i == 15) v[27:26] = flg;
        return v;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && k++ < 20) @(posedge core_clk);
        if (pready !== 1'b1) n_mismatch++;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // status polls are bounded so a stuck flag cannot hang the run
    task automatic poll(input int b, input logic v);
        for (int t = 0; t < 100; t++) begin
            apb(1'b0, OFF_STAT, 32'h0);
            if (q[b] === v) break;
        end
    endtask
    task automatic step_exp(input logic [7:0] wd, input logic prog);
        left = left - 8'h01;
        pos = pos + 12'h001;
        if (left == 8'h00) begin
            left = wd;
            if (prog && !pass) begin
                pass = 1'b1;
                pos = pos - {4'h0, wd};
            end else begin
                pass = 1'b0;
                lines = lines - 8'h01;
            end
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========
    // watchdog, far beyond the expected run
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    // ==========
    // main sequence
    initial begin
        rstn = 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        apb(1'b0, OFF_STAT, 32'h0);
        chk(q, 32'h0, "status after reset");
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        $display("test reset done");
        // progressive two-pass surface, then interlaced from a random position
        for (int m = 0; m < 2; m++) begin
            rnd = nx(rnd);
            pos = m ? rnd[11:0] : 12'h000;
            pass = 1'b0;
            left = m ? 8'h03 : 8'h02;
            lines = m ? 8'h01 : 8'h02;
            apb(1'b1, OFF_PARM, {23'h0, m == 0, left});
            apb(1'b1, OFF_POS, {20'h0, pos});
            apb(1'b1, OFF_LEFT, {16'h0, lines, left});
            while (lines != 8'h00) begin
                logic [11:0] p;
                p = pos;
                apb(1'b1, OFF_CMD, 32'h29);
                apb(1'b0, OFF_STAT, 32'h0);
                chk(q & 32'h20, 32'h0, "done cleared");
                poll(5, 1'b1);
                chk(q & 32'h20, 32'h20, "done set");
                step_exp(m ? 8'h03 : 8'h02, m == 0);
                apb(1'b0, OFF_LEFT, 32'h0);
                chk(q, {16'h0, lines, left}, "left");
                apb(1'b0, OFF_POS, 32'h0);
                chk(q, {19'h0, pass, pos}, "pos");
                w = mw(p, 6'd23);
                apb(1'b0, 12'h6e0, 32'h0);
                chk(q, {16'h0, {2{w[13]}}, w[13:0]}, "result x");
                w = mw(p, 6'd2);
                apb(1'b0, 12'h444, 32'h0);
                chk(q, {16'h0, {4{w[25]}}, w[25:14]}, "result y");
            end
            $display("test read mode %0d done", m);
        end
        apb(1'b1, OFF_CMD, 32'h29);
        repeat (60) @(posedge core_clk);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(q & 32'h20, 32'h0, "failed read done");
        apb(1'b0, OFF_POS, 32'h0);
        chk(q, {19'h0, pass, pos}, "pos kept");
        $display("test failed read done");
        // stage one macroblock, aliasing the ignored address fields
        for (int i = 0; i < 16; i++) begin
            rnd = nx(rnd);
            {zf[i], sy[i], sx[i]} = rnd[26:0];
            apb(1'b1, 12'h200 + 12'(i * 32), {18'h0, sx[i]});
            apb(1'b1, 12'h204 + 12'(i * 32), {20'h0, sy[i]});
            apb(1'b1, 12'h20c + 12'(i * 32), {31'h0, zf[i]});
            if (i < 4) reference_picture_id[i] = rnd[31:27];
            if (i < 4) apb(1'b1, 12'h208 + 12'(i * 160), {27'h0, reference_picture_id[i]});
        end
        flg = rnd[29:28];
        apb(1'b1, 12'h390, {30'h0, flg});
        apb(1'b1, 12'h294, 32'h1);
        apb(1'b1, OFF_CMD, 32'h2a);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(q & 32'hc0, 32'hc0, "gather and full");
        apb(1'b1, OFF_CMD, 32'h2a);
        poll(7, 1'b0);
        apb(1'b1, OFF_CMD, 32'h2a);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(q & 32'h80, 32'h0, "gather end");
        poll(6, 1'b0);
        chk(32'(outq.size()), 32'd16, "words out");
        for (int i = 0; i < 16 && i < outq.size(); i++) begin
            chk(outq[i][31:0], expw(i), "packed word");
            chk({31'h0, outq[i][32]}, {31'h0, i == 15}, "last flag");
        end
        $display("test write done");
        complete_run();
    end
endmodule
